// *** rtl/override_code_decode.sv ***
// Coded spindle override selection to percent
`timescale 1ns/100ps
`default_nettype none
`include "spindle_map.svh"
module override_code_decode (
  // Code bits {sp4, sp2, sp1}
  input wire logic [2:0] code,
  // Override percent
  output logic [7:0] pct
);
  // -------------------------------------------------
  // Code table, 50 to 120 percent in steps of ten
  // -------------------------------------------------
  always_comb
  begin
    unique case (code)
      3'h7: pct = `OVR_50;
      3'h3: pct = `OVR_60;
      3'h2: pct = `OVR_70;
      3'h6: pct = `OVR_80;
      3'h4: pct = `OVR_90;
      3'h0: pct = `OVR_100;
      3'h1: pct = `OVR_110;
      3'h5: pct = `OVR_120;
    endcase
  end
endmodule : override_code_decode
`default_nettype wire

// *** rtl/speed_divider.sv ***
// Iterative restoring divider for the speed scaling
`timescale 1ns/100ps
`default_nettype none
`include "spindle_map.svh"
module speed_divider (
  // Clocking
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Operands
  input wire logic start,
  input wire logic [39:0] num,
  input wire logic [23:0] den,
  // Result
  output logic busy,
  output logic done,
  output logic [39:0] quot
);
  logic [39:0] q_r, q_nxt;  // Quotient, shifts in from the right
  logic [24:0] rem_r, rem_nxt;  // Partial remainder
  logic [23:0] den_r, den_nxt;  // Held divisor
  logic [5:0] cnt_r, cnt_nxt;  // Steps still to go
  logic done_r, done_nxt;  // One-cycle finish pulse
  logic [24:0] trial;
  // -------------------------------------------------
  // One quotient bit per cycle; a zero divisor gives all ones
  // -------------------------------------------------
  always_comb
  begin
    trial = {rem_r[23:0], q_r[39]};
    q_nxt = q_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (cnt_r != 6'h00)
    begin
      q_nxt = {q_r[38:0], 1'b0};
      rem_nxt = trial;
      if (trial >= {1'b0, den_r})
      begin
        rem_nxt = trial - {1'b0, den_r};
        q_nxt[0] = 1'b1;
      end
      cnt_nxt = cnt_r - 6'h01;
      done_nxt = (cnt_r == 6'h01);
    end
    else if (start)
    begin
      // Latch operands so the result matches one snapshot
      q_nxt = num;
      rem_nxt = '0;
      den_nxt = den;
      cnt_nxt = `DIV_STEPS;
    end
  end
  // Register stage, frozen while ce is low
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else if (ce)
    begin
      q_r <= q_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
  assign busy = (cnt_r != 6'h00);
  assign done = done_r;
  assign quot = q_r;
endmodule : speed_divider
`default_nettype wire

// *** rtl/spindle_map.svh ***
// Address map, reset values and scaling constants of the spindle speed block
`ifndef SPINDLE_MAP_SVH
`define SPINDLE_MAP_SVH
// Register byte addresses (low 8 address bits decoded)
`define ADDR_CTRL 8'h00
`define ADDR_SCMD 8'h04
`define ADDR_FOVR 8'h08
`define ADDR_ORSP 8'h0C
`define ADDR_STAT 8'h40
// Table areas, bits [7:4] of the address; bits [3:2] pick the gear stage
`define AREA_LIM 4'h1
`define AREA_MAX 4'h2
`define AREA_SFT 4'h3
// Control register bit positions
`define CB_GEAR_LO 0
`define CB_GEAR_HI 1
`define CB_ZERO_HOLD 2
`define CB_SHIFT_RUN 3
`define CB_ORIENT_RUN 4
`define CB_RUN_CCW 5
`define CB_RUN_CW 6
`define CB_ORIENT_POS 7
`define CB_OVR_METHOD 8
`define CB_OVR_SP1 9
`define CB_OVR_SP2 10
`define CB_OVR_SP4 11
`define CTRL_BITS 12
// Reset values
`define CTRL_RST 12'h000
`define SCMD_RST 16'h0000
`define FOVR_RST 8'h64
`define ORSP_RST 16'h0000
`define LIM_RST 16'hFFFF
`define MAX_RST 16'hFFFF
`define SFT_RST 16'h0000
// Scaling: full-scale analog word and percent unit
`define FULL_SCALE 12'hFFF
`define PCT_UNIT 8'h64
// Override code to percent
`define OVR_50 8'h32
`define OVR_60 8'h3C
`define OVR_70 8'h46
`define OVR_80 8'h50
`define OVR_90 8'h5A
`define OVR_100 8'h64
`define OVR_110 8'h6E
`define OVR_120 8'h78
// Divider step count
`define DIV_STEPS 6'h28
`define HTRANS_NONSEQ_BIT 1
`endif

// *** rtl/spindle_pkg.sv ***
// Types shared by the spindle speed block
package spindle_pkg;
  // Source of the analog speed word
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STOP = 2'b01,
    MODE_SHIFT = 2'b10,
    MODE_ORIENT = 2'b11
  } speed_mode_t;
  // Run direction state
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_CCW = 2'b01,
    RUN_CW = 2'b10,
    RUN_LOCK = 2'b11
  } run_state_t;
endpackage : spindle_pkg

// *** rtl/spindle_speed_command_select.sv ***
// Spindle speed word and run direction with an AHB-Lite register slave
// Operation
// - Gear pair 00..11 selects stages one to four
// - Per-gear limit speed equals full-scale output
// - Speed = cmd / limit * ovr/100 * full
// - Command clamped to per-gear maximum first
// - Zero hold forces speed word to zero unless a slow run is selected
// - Coded override ignored during zero hold
// - Gear change input selects slow shift speed
// - Shift speed per gear, scaled by limit
// - Orientation speed, one value, scaled by limit
// - Counter-clockwise request runs drive counter-clockwise
// - Released run request stops the drive
// - Both directions stop until both released
// - No rotation while speed word is zero
// - Orient request overrides run requests
// - Clockwise request runs drive clockwise
// - Override codes give 50 to 120 percent
// - Method bit picks code or file override
`timescale 1ns/100ps
`default_nettype none
`include "spindle_map.svh"
module spindle_speed_command_select (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Spindle drive
  output logic [11:0] speed_data,
  output logic run_ccw,
  output logic run_cw,
  output spindle_pkg::speed_mode_t speed_mode
);
  import spindle_pkg::*;

  // -------------------------------------------------
  // Bus phase tracking
  // -------------------------------------------------
  logic wr_pend_r, wr_pend_nxt;  // Write data phase pending
  logic [7:0] addr_r, addr_nxt;  // Latched byte address
  logic [31:0] rdata_r, rdata_nxt;  // Read data for the data phase
  logic addr_phase;
  logic [31:0] rd_sel;

  // -------------------------------------------------
  // Software-visible configuration
  // -------------------------------------------------
  logic [`CTRL_BITS-1:0] ctrl_r, ctrl_nxt;  // Sequence input bits
  logic [15:0] scmd_r, scmd_nxt;  // Programmed S command
  logic [7:0] fovr_r, fovr_nxt;  // File register override percent
  logic [15:0] orsp_r, orsp_nxt;  // Orientation speed
  logic [15:0] lim_r [4];  // Limit speed per gear
  logic [15:0] max_r [4];  // Maximum speed per gear
  logic [15:0] sft_r [4];  // Gear change speed per gear
  logic [15:0] lim_nxt [4];
  logic [15:0] max_nxt [4];
  logic [15:0] sft_nxt [4];

  // -------------------------------------------------
  // Speed path and run state
  // -------------------------------------------------
  logic [1:0] gear;
  logic [15:0] cmd_clamp;
  logic [7:0] code_pct, ovr_pct;
  speed_mode_t mode;
  logic [39:0] num;
  logic [23:0] den;
  logic div_busy, div_done;
  logic [39:0] quot;
  logic [11:0] calc_r, calc_nxt;  // Last finished scaling
  logic [11:0] spd_r, spd_nxt;  // Speed word to the drive
  speed_mode_t mode_r;
  run_state_t run_r, run_nxt;
  logic ccw_r, ccw_nxt, cw_r, cw_nxt;
  logic req_ccw, req_cw, req_orient;

  // -------------------------------------------------
  // Bus slave: zero wait, always OKAY
  // -------------------------------------------------
  assign addr_phase = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_sel = '0;
    unique case (haddr[7:4])
      `AREA_LIM: rd_sel[15:0] = lim_r[haddr[3:2]];
      `AREA_MAX: rd_sel[15:0] = max_r[haddr[3:2]];
      `AREA_SFT: rd_sel[15:0] = sft_r[haddr[3:2]];
      default:
      begin
        if (haddr[7:0] == `ADDR_CTRL) rd_sel[`CTRL_BITS-1:0] = ctrl_r;
        else if (haddr[7:0] == `ADDR_SCMD) rd_sel[15:0] = scmd_r;
        else if (haddr[7:0] == `ADDR_FOVR) rd_sel[7:0] = fovr_r;
        else if (haddr[7:0] == `ADDR_ORSP) rd_sel[15:0] = orsp_r;
        else if (haddr[7:0] == `ADDR_STAT) rd_sel[17:0] = {cw_r, ccw_r, mode_r, calc_r, 2'b00};
      end
    endcase
  end

  // Read data is fetched at the address phase so it stands in the data phase
  always_comb
  begin
    wr_pend_nxt = addr_phase && hwrite;
    addr_nxt = addr_phase ? haddr[7:0] : addr_r;
    rdata_nxt = (addr_phase && !hwrite) ? rd_sel : rdata_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= '0;
      rdata_r <= '0;
    end
    else if (ce)
    begin
      wr_pend_r <= wr_pend_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // -------------------------------------------------
  // Register writes in the data phase
  // -------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    scmd_nxt = scmd_r;
    fovr_nxt = fovr_r;
    orsp_nxt = orsp_r;
    if (wr_pend_r)
    begin
      if (addr_r == `ADDR_CTRL) ctrl_nxt = hwdata[`CTRL_BITS-1:0];
      if (addr_r == `ADDR_SCMD) scmd_nxt = hwdata[15:0];
      if (addr_r == `ADDR_FOVR) fovr_nxt = hwdata[7:0];
      if (addr_r == `ADDR_ORSP) orsp_nxt = hwdata[15:0];
    end
  end

  // Per-gear tables, one entry per stage
  for (genvar g = 0; g < 4; g++)
  begin : gear_tab
    assign lim_nxt[g] = (wr_pend_r && addr_r[7:4] == `AREA_LIM && addr_r[3:2] == 2'(g)) ? hwdata[15:0] : lim_r[g];
    assign max_nxt[g] = (wr_pend_r && addr_r[7:4] == `AREA_MAX && addr_r[3:2] == 2'(g)) ? hwdata[15:0] : max_r[g];
    assign sft_nxt[g] = (wr_pend_r && addr_r[7:4] == `AREA_SFT && addr_r[3:2] == 2'(g)) ? hwdata[15:0] : sft_r[g];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RST;
      scmd_r <= `SCMD_RST;
      fovr_r <= `FOVR_RST;
      orsp_r <= `ORSP_RST;
      lim_r <= '{default: `LIM_RST};
      max_r <= '{default: `MAX_RST};
      sft_r <= '{default: `SFT_RST};
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
      scmd_r <= scmd_nxt;
      fovr_r <= fovr_nxt;
      orsp_r <= orsp_nxt;
      lim_r <= lim_nxt;
      max_r <= max_nxt;
      sft_r <= sft_nxt;
    end
  end

  // -------------------------------------------------
  // Speed selection and scaling operands
  // -------------------------------------------------
  override_code_decode override_code_decode_inst (
    .code({ctrl_r[`CB_OVR_SP4], ctrl_r[`CB_OVR_SP2], ctrl_r[`CB_OVR_SP1]}),
    .pct(code_pct)
  );

  // The gear bits are trusted to match the engaged stage
  always_comb
  begin
    gear = {ctrl_r[`CB_GEAR_HI], ctrl_r[`CB_GEAR_LO]};
    cmd_clamp = (scmd_r > max_r[gear]) ? max_r[gear] : scmd_r;
    // Zero hold uses unity override, the code is ignored
    if (ctrl_r[`CB_ZERO_HOLD]) ovr_pct = `PCT_UNIT;
    else if (ctrl_r[`CB_OVR_METHOD]) ovr_pct = fovr_r;
    else ovr_pct = code_pct;
    // Slow runs only count under zero hold and
    if (!ctrl_r[`CB_ZERO_HOLD]) mode = MODE_NORMAL;
    else if (ctrl_r[`CB_SHIFT_RUN]) mode = MODE_SHIFT;
    else if (ctrl_r[`CB_ORIENT_RUN]) mode = MODE_ORIENT;
    else mode = MODE_STOP;
    // Denominator is limit times 100 so all modes share one divide
    den = 24'(lim_r[gear]) * 24'(`PCT_UNIT);
    unique case (mode)
      MODE_NORMAL: num = 40'(cmd_clamp) * 40'(ovr_pct) * 40'(`FULL_SCALE);
      MODE_SHIFT: num = 40'(sft_r[gear]) * 40'(`PCT_UNIT) * 40'(`FULL_SCALE);
      MODE_ORIENT: num = 40'(orsp_r) * 40'(`PCT_UNIT) * 40'(`FULL_SCALE);
      MODE_STOP: num = '0;
    endcase
  end

  // Divider runs back to back; inputs are re-sampled every pass
  speed_divider speed_divider_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .start(!div_busy),
    .num(num),
    .den(den),
    .busy(div_busy),
    .done(div_done),
    .quot(quot)
  );

  // -------------------------------------------------
  // Speed word and run direction
  // -------------------------------------------------
  assign req_ccw = ctrl_r[`CB_RUN_CCW];
  assign req_cw = ctrl_r[`CB_RUN_CW];
  assign req_orient = ctrl_r[`CB_ORIENT_POS];

  always_comb
  begin
    calc_nxt = calc_r;
    if (div_done) calc_nxt = (quot > 40'(`FULL_SCALE)) ? `FULL_SCALE : quot[11:0];
    // Zero hold is immediate, not waiting for the divider
    spd_nxt = (mode == MODE_STOP) ? '0 : calc_nxt;
    // Both requests lock out until both are released
    unique case (run_r)
      RUN_LOCK: run_nxt = (!req_ccw && !req_cw) ? RUN_IDLE : RUN_LOCK;
      RUN_IDLE, RUN_CCW, RUN_CW:
      begin
        if (req_ccw && req_cw) run_nxt = RUN_LOCK;
        else if (req_ccw) run_nxt = RUN_CCW;
        else if (req_cw) run_nxt = RUN_CW;
        else run_nxt = RUN_IDLE;
      end
    endcase
    // A zero word or an orient request keeps the drive off
    ccw_nxt = (run_nxt == RUN_CCW) && !req_orient && (spd_nxt != '0);
    cw_nxt = (run_nxt == RUN_CW) && !req_orient && (spd_nxt != '0);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      calc_r <= '0;
      spd_r <= '0;
      mode_r <= MODE_NORMAL;
      run_r <= RUN_IDLE;
      ccw_r <= 1'b0;
      cw_r <= 1'b0;
    end
    else if (ce)
    begin
      calc_r <= calc_nxt;
      spd_r <= spd_nxt;
      mode_r <= mode;
      run_r <= run_nxt;
      ccw_r <= ccw_nxt;
      cw_r <= cw_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign speed_data = spd_r;
  assign run_ccw = ccw_r;
  assign run_cw = cw_r;
  assign speed_mode = mode_r;

  // -------------------------------------------------
  // Checks
  // -------------------------------------------------
  chk_stop_zero_word: assert property (@(posedge sys_clk) disable iff (rst)
    ce && mode == MODE_STOP |=> spd_r == '0)
    else $error("speed word not zero under zero hold");
  chk_both_runs_lock: assert property (@(posedge sys_clk) disable iff (rst)
    ce && req_ccw && req_cw |=> !ccw_r && !cw_r)
    else $error("drive runs with both directions requested");
  chk_lock_hold: assert property (@(posedge sys_clk) disable iff (rst)
    ce && run_r == RUN_LOCK && (req_ccw || req_cw) |=> run_r == RUN_LOCK)
    else $error("lockout left before both requests released");
  chk_orient_wins: assert property (@(posedge sys_clk) disable iff (rst)
    ce && req_orient |=> !ccw_r && !cw_r)
    else $error("run output with orient request");
  chk_zero_no_turn: assert property (@(posedge sys_clk) disable iff (rst)
    spd_r == '0 |-> !ccw_r && !cw_r)
    else $error("drive turning with zero speed word");
  chk_ccw_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(ccw_r) |-> $past(req_ccw) && !$past(req_cw))
    else $error("ccw run without sole ccw request");
  chk_cw_cause: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(cw_r) |-> $past(req_cw) && !$past(req_ccw))
    else $error("cw run without sole cw request");
  chk_release_stops: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !req_ccw && !req_cw |=> !ccw_r && !cw_r)
    else $error("drive still running after release");
  chk_clamp_max: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_clamp <= max_r[gear] && cmd_clamp <= scmd_r)
    else $error("command above gear maximum");
  chk_ovr_range: assert property (@(posedge sys_clk) disable iff (rst)
    ovr_pct >= `OVR_50 && ovr_pct <= `OVR_120 || ctrl_r[`CB_OVR_METHOD])
    else $error("coded override out of range");
  chk_shift_first: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_r[`CB_ZERO_HOLD] && ctrl_r[`CB_SHIFT_RUN] |-> mode == MODE_SHIFT)
    else $error("gear change slow run not selected");
endmodule : spindle_speed_command_select
`default_nettype wire

// *** verif/sequence_bus_model.sv ***
// Sequence-side model: an AHB-Lite master that hands control words to the spindle block
`timescale 1ns/100ps
`default_nettype none
`include "spindle_map.svh"
module sequence_bus_model (
  // Clock
  input wire logic sys_clk,
  // Bus answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Last control word written, used to order the handshake with the block
  logic [31:0] last_ctrl;

  // ----------------------------------------
  // Idle bus at time zero
  // ----------------------------------------
  initial
  begin
    last_ctrl = 32'h0000_0000;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // ----------------------------------------
  // One single word transfer
  // ----------------------------------------
  // Data bus is inverted after the data phase so a stale word never passes for fresh
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rdata = hrdata;
    hwdata <= ~wdata;
  endtask : xfer

  task automatic write_word(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] unused;
    xfer(1'b1, addr, wdata, unused);
    if (addr == `ADDR_CTRL)
    begin
      last_ctrl = wdata;
    end
  endtask : write_word

  task automatic read_word(input logic [7:0] addr, output logic [31:0] rdata);
    xfer(1'b0, addr, 32'h0000_0000, rdata);
  endtask : read_word

  // ----------------------------------------
  // Control word with the sequence side's ordering duties
  // ----------------------------------------
  task automatic apply_ctrl(input logic [31:0] val);
    logic [31:0] slow;
    logic [31:0] dirs;
    slow = (32'h1 << `CB_SHIFT_RUN) | (32'h1 << `CB_ORIENT_RUN);
    dirs = (32'h1 << `CB_RUN_CCW) | (32'h1 << `CB_RUN_CW);
    // Zero hold goes on first, slow runs only on top of it
    if (((val & slow) != 0) && !last_ctrl[`CB_ZERO_HOLD])
    begin
      write_word(`ADDR_CTRL, last_ctrl | (32'h1 << `CB_ZERO_HOLD));
    end
    // A locked direction pair is released before one direction is asked again
    if (((last_ctrl & dirs) == dirs) && ((val & dirs) != dirs))
    begin
      write_word(`ADDR_CTRL, last_ctrl & ~dirs);
    end
    // Gear bits always carry the engaged stage
    write_word(`ADDR_CTRL, val);
  endtask : apply_ctrl
endmodule : sequence_bus_model
`default_nettype wire

// *** verif/spindle_speed_command_select_test.sv ***
// Self-checking testbench of the spindle speed block
`timescale 1ns/100ps
`default_nettype none
`include "spindle_map.svh"
module spindle_speed_command_select_test;
  import spindle_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Tied: freezing is not under test
  logic hsel, hwrite, hready, hreadyout, hresp, run_ccw, run_cw;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] speed_data;
  speed_mode_t speed_mode;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  longint lim [4];
  longint smax [4];
  longint sft [4];
  logic [2:0] codes [8] = '{3'h7, 3'h3, 3'h2, 3'h6, 3'h4, 3'h0, 3'h1, 3'h5};
  // Control bits used below
  localparam logic [31:0] HOLD = 32'h1 << `CB_ZERO_HOLD;
  localparam logic [31:0] SHIFT = 32'h1 << `CB_SHIFT_RUN;
  localparam logic [31:0] ORIENT = 32'h1 << `CB_ORIENT_RUN;
  localparam logic [31:0] CCW = 32'h1 << `CB_RUN_CCW;
  localparam logic [31:0] CW = 32'h1 << `CB_RUN_CW;
  localparam logic [31:0] ORPOS = 32'h1 << `CB_ORIENT_POS;
  localparam logic [31:0] METHOD = 32'h1 << `CB_OVR_METHOD;
  localparam longint SCMD = 1800;
  localparam longint ORSP = 300;

  always #5 sys_clk = ~sys_clk;
  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // ----------------------------------------
  // Design and sequence-side model
  // ----------------------------------------
  spindle_speed_command_select spindle_speed_command_select_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .speed_data(speed_data), .run_ccw(run_ccw), .run_cw(run_cw),
    .speed_mode(speed_mode)
  );
  sequence_bus_model sequence_bus_model_inst (
    .sys_clk(sys_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Expected analog word: clipped to full scale, limit zero reads as full scale
  function automatic logic [11:0] scale(input longint num, input longint limit);
    longint q;
    if (limit == 0)
    begin
      return 12'hFFF;
    end
    q = num / (limit * 100);
    return (q > 4095) ? 12'hFFF : q[11:0];
  endfunction : scale

  function automatic longint normal_num(input int g, input longint pct);
    return ((SCMD < smax[g]) ? SCMD : smax[g]) * pct * 4095;
  endfunction : normal_num

  // Divider may need two passes after a change, so wait the full settling time
  task automatic expect_speed(input logic [11:0] word, input speed_mode_t mode);
    repeat (86) @(posedge sys_clk);
    check("speed_data", {20'h0_0000, speed_data}, {20'h0_0000, word});
    check("speed_mode", {30'h0, speed_mode}, {30'h0, mode});
  endtask : expect_speed

  task automatic expect_run(input logic ccw, input logic cw);
    repeat (4) @(posedge sys_clk);
    check("run_ccw", {31'h0, run_ccw}, {31'h0, ccw});
    check("run_cw", {31'h0, run_cw}, {31'h0, cw});
  endtask : expect_run

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    sequence_bus_model_inst.read_word(`ADDR_FOVR, rd);
    check("fovr reset", rd, 32'h0000_0064);
    sequence_bus_model_inst.read_word({`AREA_LIM, 4'h0}, rd);
    check("limit reset", rd, 32'h0000_FFFF);
    sequence_bus_model_inst.read_word({`AREA_SFT, 4'hC}, rd);
    check("shift reset", rd, 32'h0000_0000);
    sequence_bus_model_inst.read_word(8'h80, rd);
    check("unmapped", rd, 32'h0000_0000);
    check("hresp", {31'h0, hresp}, 32'h0000_0000);
    check("speed reset", {20'h0_0000, speed_data}, 32'h0000_0000);
    // Per-gear tables; gear 0 maximum lies below the command to exercise the clamp
    for (int g = 0; g < 4; g++)
    begin
      lim[g] = 2000 + 1000 * g;
      smax[g] = 1500 + 1000 * g;
      sft[g] = 100 + 50 * g;
      sequence_bus_model_inst.write_word({`AREA_LIM, g[1:0], 2'b00}, lim[g][31:0]);
      sequence_bus_model_inst.write_word({`AREA_MAX, g[1:0], 2'b00}, smax[g][31:0]);
      sequence_bus_model_inst.write_word({`AREA_SFT, g[1:0], 2'b00}, sft[g][31:0]);
    end
    sequence_bus_model_inst.write_word(`ADDR_SCMD, SCMD[31:0]);
    sequence_bus_model_inst.write_word(`ADDR_ORSP, ORSP[31:0]);
    sequence_bus_model_inst.read_word({`AREA_LIM, 4'hC}, rd);
    check("limit readback", rd, lim[3][31:0]);
    // Normal speed in every gear stage
    for (int g = 0; g < 4; g++)
    begin
      sequence_bus_model_inst.apply_ctrl(g);
      expect_speed(scale(normal_num(g, 100), lim[g]), MODE_NORMAL);
    end
    // Every override code
    for (int i = 0; i < 8; i++)
    begin
      sequence_bus_model_inst.apply_ctrl(32'h1 | ({29'h0, codes[i]} << `CB_OVR_SP1));
      expect_speed(scale(normal_num(1, 50 + 10 * i), lim[1]), MODE_NORMAL);
    end
    // File override replaces the code
    sequence_bus_model_inst.write_word(`ADDR_FOVR, 32'h0000_004B);
    sequence_bus_model_inst.apply_ctrl(32'h1 | METHOD | (32'h7 << `CB_OVR_SP1));
    expect_speed(scale(normal_num(1, 75), lim[1]), MODE_NORMAL);
    // Zero hold with the 50 percent code selected
    sequence_bus_model_inst.apply_ctrl(32'h1 | HOLD | (32'h7 << `CB_OVR_SP1));
    expect_speed(12'h000, MODE_STOP);
    // Gear change slow run per stage
    for (int g = 0; g < 4; g++)
    begin
      sequence_bus_model_inst.apply_ctrl(g | HOLD | SHIFT | (32'h7 << `CB_OVR_SP1));
      expect_speed(scale(sft[g] * 100 * 4095, lim[g]), MODE_SHIFT);
    end
    // Orientation slow run, one speed, in stages three and four
    for (int g = 2; g < 4; g++)
    begin
      sequence_bus_model_inst.apply_ctrl(g | HOLD | ORIENT);
      expect_speed(scale(ORSP * 100 * 4095, lim[g]), MODE_ORIENT);
    end
    sequence_bus_model_inst.apply_ctrl(32'h3 | HOLD | SHIFT | ORIENT);
    expect_speed(scale(sft[3] * 100 * 4095, lim[3]), MODE_SHIFT);
    // Release of zero hold restores the normal word
    sequence_bus_model_inst.apply_ctrl(32'h3 | (32'h7 << `CB_OVR_SP1));
    expect_speed(scale(normal_num(3, 50), lim[3]), MODE_NORMAL);
    // Orientation slow run without zero hold has no effect
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3 | ORIENT);
    expect_speed(scale(normal_num(3, 100), lim[3]), MODE_NORMAL);
    // Run directions, release and lock
    sequence_bus_model_inst.apply_ctrl(32'h3 | CCW);
    expect_run(1'b1, 1'b0);
    sequence_bus_model_inst.apply_ctrl(32'h3);
    expect_run(1'b0, 1'b0);
    sequence_bus_model_inst.apply_ctrl(32'h3 | CW);
    expect_run(1'b0, 1'b1);
    sequence_bus_model_inst.apply_ctrl(32'h3 | CW | CCW);
    expect_run(1'b0, 1'b0);
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3 | CCW);
    expect_run(1'b0, 1'b0);
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3);
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3 | CCW);
    expect_run(1'b1, 1'b0);
    // Reset in mid-run stops the drive; the sequence then retoggles its run request
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    check("run_ccw reset", {31'h0, run_ccw}, 32'h0000_0000);
    sequence_bus_model_inst.write_word(`ADDR_SCMD, SCMD[31:0]);
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3);
    sequence_bus_model_inst.write_word(`ADDR_CTRL, 32'h3 | CCW);
    expect_speed(scale(SCMD * 409500, 65535), MODE_NORMAL);
    check("run_ccw retoggle", {31'h0, run_ccw}, 32'h0000_0001);
    // Orient request wins over a run request
    sequence_bus_model_inst.apply_ctrl(32'h3 | CCW | ORPOS);
    expect_run(1'b0, 1'b0);
    // Zero speed word keeps the motor still
    sequence_bus_model_inst.write_word(`ADDR_SCMD, 32'h0000_0000);
    sequence_bus_model_inst.apply_ctrl(32'h3 | CCW);
    expect_speed(12'h000, MODE_NORMAL);
    check("run_ccw zero", {31'h0, run_ccw}, 32'h0000_0000);
    end_of_test();
  end
endmodule : spindle_speed_command_select_test
`default_nettype wire
